// ---- design/rfs_supervisor.v ----
// fault supervisor for two regulator rails (core rail 0, aux rail 1)
// assumes analog comparators outside deliver threshold results as levels
// Functional notes
// - phase current imbalance above 9mV held for 1ms latches an imbalance fault and shuts the rail.
// - output more than 325mV below target flags undervoltage, drops output ok and tri-states switches.
// - output more than 325mV above target flags overvoltage, drops output ok and turns low-side on.
// - low-side stays on until output falls below target, then the lower gate is tri-stated.
// - a new overvoltage after tri-state repeats the low-side pull-down.
// - either thermistor at or below 640mV asserts the hot alert.
// - an up/down thermal counter counts up under warning toward at least 100us and down otherwise.
// - after the alert trips the comparison uses the reset level 20mV higher.
// - the alert releases only when both thermistors exceed the reset level, then trip level returns.
// - a thermistor at or below 580mV declares a thermal fault, drops output ok and tri-states.
// - a thermal fault on either thermistor shuts down both rails.
// - latched faults hold until enable goes low or supply power-on reset.
// - on enable and supply return the latches clear and soft-start runs.
// - overcurrent asserts the hot alert within 2us and releases it if it clears before timeout.
// - overcurrent persisting 7.5us to 11us latches a fault, tri-states, drops output ok, stops other rail.
// - severe overcurrent shuts down at once with no timer and stops the other rail.
`timescale 1ns/1ps
`include "rfs_consts.vh"
module rfs_supervisor #(
  parameter IMBAL_CYCLES = `RFS_IMBAL_CYCLES,
  parameter THERM_CYCLES = `RFS_THERM_CYCLES,
  parameter OC_CYCLES    = `RFS_OC_CYCLES,
  parameter SS_CYCLES    = `RFS_SS_CYCLES
) (
  input  wire       clk_sys,
  input  wire       rst_b,
  input  wire       clk_en,
  input  wire       enable,
  input  wire       supply_ok,
  input  wire [1:0] imbal_cmp,
  input  wire [1:0] uv_cmp,
  input  wire [1:0] ov_cmp,
  input  wire [1:0] below_target_cmp,
  input  wire [1:0] oc_cmp,
  input  wire [1:0] severe_oc_cmp,
  input  wire [1:0] ntc_trip_cmp,
  input  wire [1:0] ntc_reset_cmp,
  input  wire [1:0] ntc_shut_cmp,
  output reg  [1:0] output_ok_flag,
  output reg  [1:0] gate_tristate,
  output reg  [1:0] low_side_on,
  output reg  [1:0] soft_start,
  output reg  [4:0] fault_flags,
  output reg        hot_threshold_sel,
  output reg        hot_alert_n
);
  // comparator senses: imbal, uv, ov, below, oc, soc, trip(<=640), reset(>660), shut(<=580)
  wire [17:0] cmp_raw = {imbal_cmp, uv_cmp, ov_cmp, below_target_cmp, oc_cmp, severe_oc_cmp,
                         ntc_trip_cmp, ntc_reset_cmp, ntc_shut_cmp};
  wire [17:0] cmp_s;
  wire [1:0]  en_s;

  rfs_sync #(.WIDTH(18)) u_sync_cmp (
    .clk_sys  (clk_sys),
    .rst_b    (rst_b),
    .clk_en   (clk_en),
    .async_in (cmp_raw),
    .sync_out (cmp_s)
  );
  rfs_sync #(.WIDTH(2)) u_sync_en (
    .clk_sys  (clk_sys),
    .rst_b    (rst_b),
    .clk_en   (clk_en),
    .async_in ({enable, supply_ok}),
    .sync_out (en_s)
  );

  wire [1:0] imbal_s  = cmp_s[17:16];
  wire [1:0] uv_s     = cmp_s[15:14];
  wire [1:0] ov_s     = cmp_s[13:12];
  wire [1:0] below_s  = cmp_s[11:10];
  wire [1:0] oc_s     = cmp_s[9:8];
  wire [1:0] soc_s    = cmp_s[7:6];
  wire [1:0] trip_s   = cmp_s[5:4];
  wire [1:0] rst_lv_s = cmp_s[3:2];
  wire [1:0] shut_s   = cmp_s[1:0];
  wire       run_ok   = en_s[1] & en_s[0];

  // fault_flags: 0 imbalance, 1 undervoltage, 2 overvoltage, 3 overcurrent, 4 thermal
  reg  [1:0]  st_q [0:1];
  reg  [19:0] imbal_cnt_q [0:1];
  reg  [9:0]  oc_cnt_q [0:1];
  reg  [15:0] ss_cnt_q [0:1];
  reg  [1:0]  uv_q;
  reg  [1:0]  ov_q;
  reg  [1:0]  ovpull_q;
  reg  [1:0]  imbf_q;
  reg  [1:0]  ocf_q;
  reg  [1:0]  shut_q;
  reg         therm_q;
  reg  [15:0] therm_cnt_q;
  reg         hot_q;

  // a rail's own shutdown cause: latched faults plus live severe overcurrent
  function rail_fault;
    input integer r;
    begin
      rail_fault = uv_q[r] | ov_q[r] | imbf_q[r] | ocf_q[r] | soc_s[r];
    end
  endfunction

  wire [1:0] own_fault = {rail_fault(1), rail_fault(0)};
  wire       any_fault = (|own_fault) | therm_q;

  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : g_rail
      always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
          st_q[g]        <= `RFS_ST_OFF;
          imbal_cnt_q[g] <= 20'h00000;
          oc_cnt_q[g]    <= 10'h000;
          ss_cnt_q[g]    <= 16'h0000;
          uv_q[g]        <= 1'b0;
          ov_q[g]        <= 1'b0;
          ovpull_q[g]    <= 1'b0;
          imbf_q[g]      <= 1'b0;
          ocf_q[g]       <= 1'b0;
          shut_q[g]      <= 1'b1;
        end else if (clk_en) begin
          if (!run_ok) begin
            st_q[g]        <= `RFS_ST_OFF;
            imbal_cnt_q[g] <= 20'h00000;
            oc_cnt_q[g]    <= 10'h000;
            uv_q[g]        <= 1'b0;
            ov_q[g]        <= 1'b0;
            ovpull_q[g]    <= 1'b0;
            imbf_q[g]      <= 1'b0;
            ocf_q[g]       <= 1'b0;
            shut_q[g]      <= 1'b1;
          end else begin
            case (st_q[g])
              `RFS_ST_OFF: begin
                if (!shut_q[g] || !any_fault) begin
                  st_q[g]     <= `RFS_ST_SOFT;
                  ss_cnt_q[g] <= 16'h0000;
                  shut_q[g]   <= 1'b0;
                end
              end
              `RFS_ST_SOFT: begin
                if (any_fault)
                  st_q[g] <= `RFS_ST_RUN;
                else if (ss_cnt_q[g] == SS_CYCLES[15:0] - 16'h0001)
                  st_q[g] <= `RFS_ST_RUN;
                else
                  ss_cnt_q[g] <= ss_cnt_q[g] + 16'h0001;
              end
              default: st_q[g] <= `RFS_ST_RUN;
            endcase
            if (imbal_s[g]) begin
              if (imbal_cnt_q[g] == IMBAL_CYCLES[19:0] - 20'h00001)
                imbf_q[g] <= 1'b1;
              else
                imbal_cnt_q[g] <= imbal_cnt_q[g] + 20'h00001;
            end else
              imbal_cnt_q[g] <= 20'h00000;
            if (oc_s[g]) begin
              if (oc_cnt_q[g] == OC_CYCLES[9:0] - 10'h001)
                ocf_q[g] <= 1'b1;
              else
                oc_cnt_q[g] <= oc_cnt_q[g] + 10'h001;
            end else
              oc_cnt_q[g] <= 10'h000;
            if (uv_s[g])
              uv_q[g] <= 1'b1;
            if (ov_s[g]) begin
              ov_q[g]     <= 1'b1;
              ovpull_q[g] <= 1'b1;
            end else if (below_s[g])
              ovpull_q[g] <= 1'b0;
          end
        end
      end

      always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
          output_ok_flag[g] <= 1'b0;
          gate_tristate[g]  <= 1'b1;
          low_side_on[g]    <= 1'b0;
          soft_start[g]     <= 1'b0;
        end else if (clk_en) begin
          output_ok_flag[g] <= run_ok && !any_fault && st_q[g] == `RFS_ST_RUN;
          low_side_on[g]    <= run_ok && ovpull_q[g];
          gate_tristate[g]  <= !run_ok || (any_fault && !ovpull_q[g]);
          soft_start[g]     <= run_ok && !any_fault && st_q[g] == `RFS_ST_SOFT;
        end
      end
    end
  endgenerate

  wire warn     = hot_q ? ~&rst_lv_s : |trip_s;
  wire oc_alert = |oc_s;

  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      therm_q     <= 1'b0;
      therm_cnt_q <= 16'h0000;
      hot_q       <= 1'b0;
    end else if (clk_en) begin
      if (|trip_s)
        hot_q <= 1'b1;
      else if (&rst_lv_s)
        hot_q <= 1'b0;
      if (warn) begin
        if (therm_cnt_q != THERM_CYCLES[15:0])
          therm_cnt_q <= therm_cnt_q + 16'h0001;
      end else if (therm_cnt_q != 16'h0000)
        therm_cnt_q <= therm_cnt_q - 16'h0001;
      if (!run_ok) begin
        therm_q     <= 1'b0;
        therm_cnt_q <= 16'h0000;
      end else if ((|shut_s) || (warn && therm_cnt_q == THERM_CYCLES[15:0]))
        therm_q <= 1'b1;
    end
  end

  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      hot_alert_n       <= 1'b1;
      hot_threshold_sel <= 1'b0;
      fault_flags       <= 5'h00;
    end else if (clk_en) begin
      hot_alert_n       <= !(hot_q || oc_alert);
      hot_threshold_sel <= hot_q;
      fault_flags       <= {therm_q, |ocf_q | |soc_s, |ov_q, |uv_q, |imbf_q};
    end
  end
endmodule // rfs_supervisor

// ---- design/rfs_consts.vh ----
// constants for the regulator fault supervisor
// assumes a 20 MHz system clock; times are given in ns
`ifndef RFS_CONSTS_VH
`define RFS_CONSTS_VH
`define RFS_CLK_PERIOD_NS     50
`define RFS_IMBAL_TIME_NS     1000000
`define RFS_IMBAL_CYCLES      ((`RFS_IMBAL_TIME_NS + `RFS_CLK_PERIOD_NS - 1) / `RFS_CLK_PERIOD_NS)
`define RFS_THERM_TIME_NS     100000
`define RFS_THERM_CYCLES      ((`RFS_THERM_TIME_NS + `RFS_CLK_PERIOD_NS - 1) / `RFS_CLK_PERIOD_NS)
`define RFS_OC_MIN_TIME_NS    7500
`define RFS_OC_CYCLES         ((`RFS_OC_MIN_TIME_NS + `RFS_CLK_PERIOD_NS - 1) / `RFS_CLK_PERIOD_NS)
`define RFS_SS_TIME_NS        1000
`define RFS_SS_CYCLES         ((`RFS_SS_TIME_NS + `RFS_CLK_PERIOD_NS - 1) / `RFS_CLK_PERIOD_NS)
`define RFS_ST_RUN            2'h0
`define RFS_ST_SOFT           2'h1
`define RFS_ST_OFF            2'h2
`endif

// ---- design/rfs_sync.v ----
// two-flop synchroniser bank for comparator inputs
// assumes asynchronous inputs and a single system clock
`timescale 1ns/1ps
module rfs_sync #(
  parameter WIDTH = 8
) (
  input  wire             clk_sys,
  input  wire             rst_b,
  input  wire             clk_en,
  input  wire [WIDTH-1:0] async_in,
  output wire [WIDTH-1:0] sync_out
);
  reg [WIDTH-1:0] meta_q;
  reg [WIDTH-1:0] sync_q;
  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
      always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
          meta_q[i] <= 1'b0;
          sync_q[i] <= 1'b0;
        end else if (clk_en) begin
          meta_q[i] <= async_in[i];
          sync_q[i] <= meta_q[i];
        end
      end
    end
  endgenerate
  assign sync_out = sync_q;
endmodule // rfs_sync

// ---- verif/rfs_supervisor_chk.sv ----
// checker for the regulator fault supervisor
// bound to rfs_supervisor; sees its ports only
`timescale 1ns/1ps
module rfs_supervisor_chk #(
  parameter OC_CYCLES = 150
) (
  input wire       clk_sys,
  input wire       rst_b,
  input wire       clk_en,
  input wire       enable,
  input wire       supply_ok,
  input wire [1:0] imbal_cmp,
  input wire [1:0] uv_cmp,
  input wire [1:0] ov_cmp,
  input wire [1:0] below_target_cmp,
  input wire [1:0] oc_cmp,
  input wire [1:0] severe_oc_cmp,
  input wire [1:0] ntc_trip_cmp,
  input wire [1:0] ntc_reset_cmp,
  input wire [1:0] ntc_shut_cmp,
  input wire [1:0] output_ok_flag,
  input wire [1:0] gate_tristate,
  input wire [1:0] low_side_on,
  input wire [1:0] soft_start,
  input wire [4:0] fault_flags,
  input wire       hot_threshold_sel,
  input wire       hot_alert_n
);
  reg [7:0] oc_run_q;
  // cycles of rail 0 overcurrent held
  always @(posedge clk_sys or negedge rst_b)
    if (!rst_b) oc_run_q <= 8'h00;
    else if (!oc_cmp[0]) oc_run_q <= 8'h00;
    else if (oc_run_q != 8'hFF) oc_run_q <= oc_run_q + 8'h01;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b || !clk_en);
  AST_UV: assert property (uv_cmp[0] [*5] |-> fault_flags[1] && output_ok_flag == 2'h0)
    else $error("uv");
  AST_OV: assert property (ov_cmp[0] [*4] |-> ##[0:2] low_side_on[0])
    else $error("ov");
  AST_SHUT: assert property (ntc_shut_cmp[1] [*5] |-> fault_flags[4] && output_ok_flag == 2'h0)
    else $error("shut");
  AST_SOC: assert property (severe_oc_cmp[1] [*5] |-> output_ok_flag == 2'h0 && gate_tristate == 2'h3)
    else $error("severe");
  AST_HOT: assert property (ntc_trip_cmp[0] [*5] |-> !hot_alert_n && hot_threshold_sel)
    else $error("hot");
  AST_OC: assert property (oc_run_q == OC_CYCLES + 6 |-> fault_flags[3] && output_ok_flag == 2'h0)
    else $error("oc");
  AST_OCH: assert property (oc_run_q == 8'h06 |-> !hot_alert_n)
    else $error("oc alert");
  AST_HOLD: assert property ((enable && supply_ok) [*4] ##0 fault_flags[1] |=> fault_flags[1])
    else $error("hold");
  AST_SS: assert property ($rose(soft_start[0]) |-> fault_flags == 5'h00)
    else $error("ss");
  cover property ($fell(hot_alert_n));
  cover property ($rose(low_side_on[0]));
  cover property ($rose(fault_flags[4]));
endmodule // rfs_supervisor_chk
bind rfs_supervisor rfs_supervisor_chk #(.OC_CYCLES(OC_CYCLES)) i_chk (
  .clk_sys           (clk_sys),
  .rst_b             (rst_b),
  .clk_en            (clk_en),
  .enable            (enable),
  .supply_ok         (supply_ok),
  .imbal_cmp         (imbal_cmp),
  .uv_cmp            (uv_cmp),
  .ov_cmp            (ov_cmp),
  .below_target_cmp  (below_target_cmp),
  .oc_cmp            (oc_cmp),
  .severe_oc_cmp     (severe_oc_cmp),
  .ntc_trip_cmp      (ntc_trip_cmp),
  .ntc_reset_cmp     (ntc_reset_cmp),
  .ntc_shut_cmp      (ntc_shut_cmp),
  .output_ok_flag    (output_ok_flag),
  .gate_tristate     (gate_tristate),
  .low_side_on       (low_side_on),
  .soft_start        (soft_start),
  .fault_flags       (fault_flags),
  .hot_threshold_sel (hot_threshold_sel),
  .hot_alert_n       (hot_alert_n)
);

// ---- verif/rfs_host.sv ----
// host model: drives enable low to clear faults
// assumes one-cycle clear_req pulses
`timescale 1ns/1ps
module rfs_host (
  input wire clk_sys,
  input wire clear_req,
  output reg enable
);
  initial enable = 1'b1;
  always @(posedge clk_sys) if (clear_req) begin
    #1 enable = 1'b0;
    repeat (4) @(posedge clk_sys);
    #1 enable = 1'b1;
  end
endmodule // rfs_host

// ---- verif/regulator_fault_supervisor_test.sv ----
// self-checking bench for the regulator fault supervisor
// drives comparator levels; rfs_host drives enable
`timescale 1ns/1ps
module regulator_fault_supervisor_test;
  reg         clk_sys = 1'b0, rst_b = 1'b0, clk_en = 1'b1, supply_ok = 1'b1, clear_req = 1'b0;
  reg  [17:0] cmp = 18'h0000C;
  wire        enable, hot_threshold_sel, hot_alert_n;
  wire [1:0]  imbal_cmp, uv_cmp, ov_cmp, below_target_cmp, oc_cmp, severe_oc_cmp;
  wire [1:0]  ntc_trip_cmp, ntc_reset_cmp, ntc_shut_cmp;
  wire [1:0]  output_ok_flag, gate_tristate, low_side_on, soft_start;
  wire [4:0]  fault_flags;
  reg  [24:0] rows [0:5];
  integer     num_errors = 0, n_checks = 0, cyc = 0, i;
  assign {imbal_cmp, uv_cmp, ov_cmp, below_target_cmp, oc_cmp, severe_oc_cmp,
          ntc_trip_cmp, ntc_reset_cmp, ntc_shut_cmp} = cmp;
  // thermal count kept above the length of the alert scenarios
  rfs_supervisor #(.IMBAL_CYCLES(8), .THERM_CYCLES(40), .OC_CYCLES(8), .SS_CYCLES(8)) i_dut (
    .clk_sys           (clk_sys),
    .rst_b             (rst_b),
    .clk_en            (clk_en),
    .enable            (enable),
    .supply_ok         (supply_ok),
    .imbal_cmp         (imbal_cmp),
    .uv_cmp            (uv_cmp),
    .ov_cmp            (ov_cmp),
    .below_target_cmp  (below_target_cmp),
    .oc_cmp            (oc_cmp),
    .severe_oc_cmp     (severe_oc_cmp),
    .ntc_trip_cmp      (ntc_trip_cmp),
    .ntc_reset_cmp     (ntc_reset_cmp),
    .ntc_shut_cmp      (ntc_shut_cmp),
    .output_ok_flag    (output_ok_flag),
    .gate_tristate     (gate_tristate),
    .low_side_on       (low_side_on),
    .soft_start        (soft_start),
    .fault_flags       (fault_flags),
    .hot_threshold_sel (hot_threshold_sel),
    .hot_alert_n       (hot_alert_n)
  );
  rfs_host i_host (.clk_sys(clk_sys), .clear_req(clear_req), .enable(enable));
  initial begin
    forever #25 clk_sys = ~clk_sys;
  end
  task tick(input integer n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task chk(input [7:0] seen, input [7:0] exp, input [8*12:1] what);
    n_checks = n_checks + 1;
    if (seen !== exp) begin
      num_errors = num_errors + 1;
      $display("MISMATCH %0s expected %h seen %h", what, exp, seen);
    end
  endtask
  task give_verdict;
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task clear_faults;
    cmp = 18'h0000C;
    clear_req = 1'b1;
    tick(1);
    clear_req = 1'b0;
    tick(40);
  endtask
  always @(posedge clk_sys) begin
    cyc = cyc + 1;
    if (cyc == 1500) begin
      num_errors = num_errors + 1;
      give_verdict;
    end
  end
  initial begin
    // {comparators, faults, output ok}
    rows[0] = {18'h0400C, 5'h02, 2'h0};
    rows[1] = {18'h0200C, 5'h04, 2'h0};
    rows[2] = {18'h1000C, 5'h01, 2'h0};
    rows[3] = {18'h0010C, 5'h08, 2'h0};
    rows[4] = {18'h00026, 5'h10, 2'h0};
    rows[5] = {18'h0000C, 5'h00, 2'h3};
    tick(5);
    chk(gate_tristate, 8'h03, "reset gates");
    chk(hot_alert_n, 8'h01, "reset hot");
    chk(output_ok_flag, 8'h00, "reset ok");
    chk(fault_flags, 8'h00, "reset faults");
    chk(low_side_on, 8'h00, "reset low");
    chk(soft_start, 8'h00, "reset soft");
    chk(hot_threshold_sel, 8'h00, "reset level");
    rst_b = 1'b1;
    tick(40);
    for (i = 0; i < 6; i = i + 1) begin
      cmp = rows[i][24:7];
      tick(20);
      chk(fault_flags, rows[i][6:2], "faults");
      chk(output_ok_flag, rows[i][1:0], "output ok");
      clear_faults;
    end
    cmp = 18'h0100C;
    tick(8);
    chk(low_side_on, 8'h01, "pull down");
    cmp = 18'h0040C;
    tick(8);
    chk(low_side_on, 8'h00, "pull off");
    chk(gate_tristate[0], 8'h01, "lower off");
    cmp = 18'h0100C;
    tick(8);
    chk(low_side_on, 8'h01, "pull again");
    clear_faults;
    cmp = 18'h00018;
    tick(6);
    chk(hot_alert_n, 8'h00, "hot trip");
    cmp = 18'h00008;
    tick(6);
    chk(hot_alert_n, 8'h00, "hot hold");
    chk(hot_threshold_sel, 8'h01, "reset thresh");
    cmp = 18'h0000C;
    tick(8);
    chk(hot_alert_n, 8'h01, "hot free");
    chk(hot_threshold_sel, 8'h00, "trip level");
    cmp = 18'h0010C;
    tick(6);
    chk(hot_alert_n, 8'h00, "oc alert");
    cmp = 18'h0000C;
    tick(6);
    chk(hot_alert_n, 8'h01, "oc alert off");
    chk(fault_flags, 8'h00, "oc timer");
    cmp = 18'h0008C;
    tick(8);
    chk(output_ok_flag, 8'h00, "severe");
    cmp = 18'h0400C;
    tick(8);
    cmp = 18'h0000C;
    tick(8);
    chk(fault_flags, 8'h02, "latched");
    supply_ok = 1'b0;
    tick(4);
    supply_ok = 1'b1;
    tick(6);
    chk(soft_start, 8'h03, "soft start");
    tick(34);
    chk(fault_flags, 8'h00, "por clear");
    chk(output_ok_flag, 8'h03, "restart");
    // warning up, back down, up again: only the up/down count faults late
    cmp = 18'h00018;
    tick(30);
    chk(fault_flags, 8'h00, "therm early");
    cmp = 18'h0000C;
    tick(20);
    cmp = 18'h00018;
    tick(20);
    chk(fault_flags, 8'h00, "therm down");
    tick(30);
    chk(fault_flags, 8'h10, "therm fault");
    chk(output_ok_flag, 8'h00, "therm both");
    give_verdict;
  end
endmodule // regulator_fault_supervisor_test
